// ### src/sar_adc_pkg.sv
// constants shared by the successive-approximation converter control logic
package sar_adc_pkg;
	localparam logic [15:0] ADDR_RESULT_HIGH = 16'hffc4;
	localparam logic [15:0] ADDR_RESULT_LOW = 16'hffc5;
	localparam logic [15:0] ADDR_MODE = 16'hffc6;
	localparam logic [15:0] ADDR_START = 16'hffc7;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hffc8;
	localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hffc9;
	localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hffca;
	localparam logic [15:0] ADDR_SPEED_INFO = 16'hffcb;
	localparam logic [15:0] ADDR_CLOCK_GATE = 16'hfffa;

	localparam logic [7:0] MODE_RESET = 8'h30;
	localparam logic [7:0] START_RESET = 8'h7f;
	localparam logic [7:0] GATE_RESET = 8'hff;
	localparam logic [1:0] MODE_RESERVED_READ = 2'h3;
	localparam logic [6:0] START_RESERVED_READ = 7'h7f;
	localparam logic [1:0] GATE_RESERVED_READ = 2'h3;
	localparam logic [7:0] READ_NONE = 8'h00;

	localparam int MODE_SPEED_BIT = 7;
	localparam int MODE_TRIG_BIT = 6;
	localparam int START_FLAG_BIT = 7;
	localparam int GATE_ADC_BIT = 4;
	localparam int IRQ_DONE_BIT = 0;

	localparam int RESULT_WIDTH = 10;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [5:0] LOW_RESULT_PAD = 6'h00;

	// channel select groups: 01xx inputs 0..3, 10xx inputs 4..7
	localparam logic [1:0] CH_GROUP_LOW = 2'h1;
	localparam logic [1:0] CH_GROUP_HIGH = 2'h2;

	// conversion length in system clock periods, sample phase, bit step spacing
	localparam logic [5:0] SLOW_CYCLES = 6'h3e;
	localparam logic [5:0] FAST_CYCLES = 6'h1f;
	localparam logic [5:0] SLOW_SAMPLE = 6'h14;
	localparam logic [5:0] FAST_SAMPLE = 6'h0a;
	localparam logic [5:0] SLOW_STEP_MASK = 6'h03;
	localparam logic [5:0] FAST_STEP_MASK = 6'h01;
	localparam logic [5:0] STEP_PHASE = 6'h01;
	localparam logic [5:0] COUNT_ONE = 6'h01;

	localparam int CLK_PERIOD_NS = 100;
	localparam int MIN_CONV_TIME_NS = 6200;
	localparam int MIN_CONV_CYCLES = (MIN_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic EDGE_RISING = 1'b1;
endpackage

// ### src/pin_sync_edge.sv
// two-flop synchronisers for comparator and trigger pin, with trigger edge detect
`timescale 1ns/1ns
module pin_sync_edge (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic comparator_in,
	input wire logic ext_trigger_pin_in,
	input wire logic trigger_edge_select_in,
	output logic comparator_sync_out,
	output logic trigger_pulse_out
);
	typedef struct packed {
		logic [1:0] stage1;
		logic [1:0] stage2;
		logic trig_prev;
		logic trig_pulse;
	} sync_state_type;

	sync_state_type st;
	sync_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.stage1 = {ext_trigger_pin_in, comparator_in};
		// stage1 feeds stage2 only; edge logic looks at stage2 and later
		next_st.stage2 = st.stage1;
		next_st.trig_prev = st.stage2[1];
		if (trigger_edge_select_in == sar_adc_pkg::EDGE_RISING) begin
			next_st.trig_pulse = st.stage2[1] & ~st.trig_prev; // see [RULE10]
		end else begin
			next_st.trig_pulse = ~st.stage2[1] & st.trig_prev; // see [RULE10]
		end
		if (sys_rst_in) begin
			next_st = '0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		st <= next_st;
	end

	assign comparator_sync_out = st.stage2[0];
	assign trigger_pulse_out = st.trig_pulse;
endmodule // pin_sync_edge

// ### src/sar_register.sv
// successive-approximation trial register, one bit decided per step
`timescale 1ns/1ns
module sar_register (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic step_in,
	input wire logic comp_in,
	output logic [9:0] trial_code_out
);
	typedef struct packed {
		logic [9:0] code;
		logic [9:0] mask;
	} sar_state_type;

	sar_state_type st;
	sar_state_type next_st;

	always_comb begin
		next_st = st;
		if (start_in) begin
			next_st.code = sar_adc_pkg::SAR_FIRST_TRIAL; // see [RULE1]
			next_st.mask = sar_adc_pkg::SAR_FIRST_TRIAL;
		end else if (step_in) begin
			// comparator high: input at or above trial, keep the bit
			next_st.mask = st.mask >> 1;
			next_st.code = (comp_in ? st.code : (st.code & ~st.mask)) | next_st.mask; // see [RULE1]
		end
		if (sys_rst_in) begin
			next_st = '0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		st <= next_st;
	end

	assign trial_code_out = st.code;

	a_first_trial: assert property ( // see [RULE1]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		start_in |=> (st.code == sar_adc_pkg::SAR_FIRST_TRIAL) && $onehot(st.mask)
	) else $error("trial register not loaded with first trial");
endmodule // sar_register

// ### src/sar_adc_control.sv
// register file, sequencer and interrupt logic of the 10-bit converter
// Functional notes
// [RULE1] converts one of up to eight inputs at a time by successive approximation
// [RULE2] completion stores a 10-bit result, held until next conversion starts
// [RULE3] upper eight bits in high register, lower two in low bits 7 and 6
// [RULE4] result registers readable anytime, contents undefined during conversion
// [RULE5] reset does not clear the result registers
// [RULE6] mode register resets to 0x30: slow speed, trigger off, no channel
// [RULE7] speed bit 0 gives 62 clock periods per conversion, bit 1 gives 31
// [RULE8] software keeps conversion time at or above the guaranteed limit
// [RULE9] trigger enable 0 means trigger pin edges never start conversion
// [RULE10] trigger enable 1 starts on the edge chosen by edge-select input
// [RULE11] every completed conversion raises an interrupt request
// [RULE12] module standby stops the converter independently of the chip
// [RULE13] start flag: write 1 starts, reads 1 while busy, write 0 stops
// [RULE14] channel bits: 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx barred
// [RULE15] completion sets done flag; interrupt only when its enable is 1
// [RULE16] qualifying trigger edge sets start flag exactly like software start
// [RULE17] sequencer counts selected periods, then completes and latches result
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module sar_adc_control (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rd_data_out,
	input wire logic ext_trigger_pin_in,
	input wire logic trigger_edge_select_in,
	input wire logic comparator_in,
	output logic [2:0] channel_out,
	output logic channel_valid_out,
	output logic sample_out,
	output logic [9:0] trial_code_out,
	output logic conversion_active_out,
	output logic irq_out
);
	typedef struct packed {
		logic conversion_speed_select;
		logic ext_trigger_enable;
		logic [3:0] channel_select;
		logic conversion_active_flag;
		logic run_speed;
		logic [5:0] count;
		logic [9:0] result;
		logic [5:0] gate_bits;
		logic conversion_done_request;
		logic conversion_done_irq_enable;
		logic [7:0] rd_data;
		logic [2:0] channel;
		logic channel_valid;
		logic sample;
		logic irq;
		logic done_seen;
	} ctl_state_type;

	ctl_state_type st;
	ctl_state_type next_st;

	logic trig_pulse;
	logic sar_start;
	logic sar_step;
	logic [9:0] sar_code;

	logic wr_start;
	logic start_write;
	logic stop_write;
	logic standby;
	logic done_evt;
	logic done_ok;
	logic [5:0] last_count;
	logic [5:0] sample_len;
	logic [5:0] step_mask;
	logic [5:0] next_sample_len;
	logic [5:0] mode_cycles;

	pin_sync_edge u_pins (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.comparator_in(comparator_in),
		.ext_trigger_pin_in(ext_trigger_pin_in),
		.trigger_edge_select_in(trigger_edge_select_in),
		.comparator_sync_out(),
		.trigger_pulse_out(trig_pulse)
	);

	sar_register u_sar (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(sar_start),
		.step_in(sar_step),
		// comparator is latched on this clock by the analog part; two more flops
		// would let each fast-mode decision see the previous trial
		.comp_in(comparator_in),
		.trial_code_out(sar_code)
	);

	always_comb begin
		next_st = st;
		// speed is frozen at start; mode changes mid-run need a stop first
		last_count = (st.run_speed ? sar_adc_pkg::FAST_CYCLES : sar_adc_pkg::SLOW_CYCLES)
			- sar_adc_pkg::COUNT_ONE; // see [RULE7]
		sample_len = st.run_speed ? sar_adc_pkg::FAST_SAMPLE : sar_adc_pkg::SLOW_SAMPLE;
		step_mask = st.run_speed ? sar_adc_pkg::FAST_STEP_MASK : sar_adc_pkg::SLOW_STEP_MASK;
		mode_cycles = st.conversion_speed_select ? sar_adc_pkg::FAST_CYCLES
			: sar_adc_pkg::SLOW_CYCLES;
		wr_start = wr_in && (addr_in == sar_adc_pkg::ADDR_START);
		start_write = wr_start && wr_data_in[sar_adc_pkg::START_FLAG_BIT];
		stop_write = wr_start && !wr_data_in[sar_adc_pkg::START_FLAG_BIT];
		standby = !st.gate_bits[sar_adc_pkg::GATE_ADC_BIT]; // see [RULE12]
		done_evt = st.conversion_active_flag && (st.count == last_count); // see [RULE17]
		done_ok = done_evt && !stop_write && !standby;
		// a trigger edge qualifies only while enabled; it acts like a start write
		sar_start = !st.conversion_active_flag && !standby
			&& (start_write || (st.ext_trigger_enable && trig_pulse)); // see [RULE9] see [RULE16]
		sar_step = st.conversion_active_flag && (st.count > sample_len)
			&& (st.count < last_count)
			&& (((st.count - sample_len) & step_mask) == sar_adc_pkg::STEP_PHASE); // see [RULE1]

		// sequencer
		if (standby || stop_write) begin
			next_st.conversion_active_flag = 1'b0; // see [RULE12] see [RULE13]
		end else if (sar_start) begin
			next_st.conversion_active_flag = 1'b1; // see [RULE13]
			next_st.count = '0;
			next_st.run_speed = st.conversion_speed_select;
		end else if (done_evt) begin
			next_st.conversion_active_flag = 1'b0; // see [RULE13]
			next_st.result = sar_code; // see [RULE2] see [RULE17]
		end else if (st.conversion_active_flag) begin
			next_st.count = st.count + sar_adc_pkg::COUNT_ONE; // see [RULE17]
		end

		// register writes
		if (wr_in && addr_in == sar_adc_pkg::ADDR_MODE) begin
			next_st.conversion_speed_select = wr_data_in[sar_adc_pkg::MODE_SPEED_BIT];
			next_st.ext_trigger_enable = wr_data_in[sar_adc_pkg::MODE_TRIG_BIT];
			next_st.channel_select = wr_data_in[3:0];
		end
		if (wr_in && addr_in == sar_adc_pkg::ADDR_CLOCK_GATE) begin
			next_st.gate_bits = wr_data_in[5:0];
		end
		if (wr_in && addr_in == sar_adc_pkg::ADDR_IRQ_ENABLE) begin
			next_st.conversion_done_irq_enable = wr_data_in[sar_adc_pkg::IRQ_DONE_BIT];
		end
		// set wins over a clear in the same cycle
		if (wr_in && addr_in == sar_adc_pkg::ADDR_IRQ_CLEAR
			&& wr_data_in[sar_adc_pkg::IRQ_DONE_BIT]) begin
			next_st.conversion_done_request = 1'b0;
		end
		if (done_ok) begin
			next_st.conversion_done_request = 1'b1; // see [RULE11] see [RULE15]
		end
		next_st.done_seen = done_ok;

		// read data valid in the cycle after the strobe only
		next_st.rd_data = sar_adc_pkg::READ_NONE;
		if (rd_in) begin
			case (addr_in)
				sar_adc_pkg::ADDR_RESULT_HIGH: begin
					next_st.rd_data = st.result[9:2]; // see [RULE3] see [RULE4]
				end
				sar_adc_pkg::ADDR_RESULT_LOW: begin
					next_st.rd_data = {st.result[1:0], sar_adc_pkg::LOW_RESULT_PAD}; // see [RULE3]
				end
				sar_adc_pkg::ADDR_MODE: begin
					next_st.rd_data = {st.conversion_speed_select, st.ext_trigger_enable,
						sar_adc_pkg::MODE_RESERVED_READ, st.channel_select};
				end
				sar_adc_pkg::ADDR_START: begin
					next_st.rd_data = {st.conversion_active_flag,
						sar_adc_pkg::START_RESERVED_READ}; // see [RULE13]
				end
				sar_adc_pkg::ADDR_IRQ_STATUS: begin
					next_st.rd_data = {7'h00, st.conversion_done_request};
				end
				sar_adc_pkg::ADDR_IRQ_ENABLE: begin
					next_st.rd_data = {7'h00, st.conversion_done_irq_enable};
				end
				sar_adc_pkg::ADDR_SPEED_INFO: begin
					// flags a speed setting below the guaranteed conversion time
					next_st.rd_data = {7'h00,
						mode_cycles < 6'(sar_adc_pkg::MIN_CONV_CYCLES)}; // see [RULE8]
				end
				sar_adc_pkg::ADDR_CLOCK_GATE: begin
					next_st.rd_data = {sar_adc_pkg::GATE_RESERVED_READ, st.gate_bits};
				end
				default: begin
					next_st.rd_data = sar_adc_pkg::READ_NONE;
				end
			endcase
		end

		// reset: result survives, everything else to its reset value
		if (sys_rst_in) begin
			next_st = '0;
			next_st.result = st.result; // see [RULE5]
			next_st.conversion_speed_select = sar_adc_pkg::MODE_RESET[sar_adc_pkg::MODE_SPEED_BIT];
			next_st.ext_trigger_enable = sar_adc_pkg::MODE_RESET[sar_adc_pkg::MODE_TRIG_BIT]; // see [RULE6]
			next_st.channel_select = sar_adc_pkg::MODE_RESET[3:0]; // see [RULE6]
			next_st.conversion_active_flag = sar_adc_pkg::START_RESET[sar_adc_pkg::START_FLAG_BIT];
			next_st.gate_bits = sar_adc_pkg::GATE_RESET[5:0];
		end

		// analog-facing outputs follow the next state
		case (next_st.channel_select[3:2])
			sar_adc_pkg::CH_GROUP_LOW: begin
				next_st.channel = {1'b0, next_st.channel_select[1:0]}; // see [RULE14]
				next_st.channel_valid = 1'b1;
			end
			sar_adc_pkg::CH_GROUP_HIGH: begin
				next_st.channel = {1'b1, next_st.channel_select[1:0]}; // see [RULE14]
				next_st.channel_valid = 1'b1;
			end
			default: begin
				// 00xx selects nothing; 11xx is barred and also selects nothing
				next_st.channel = 3'h0;
				next_st.channel_valid = 1'b0;
			end
		endcase
		next_sample_len = next_st.run_speed ? sar_adc_pkg::FAST_SAMPLE
			: sar_adc_pkg::SLOW_SAMPLE;
		next_st.sample = next_st.conversion_active_flag && (next_st.count <= next_sample_len);
		next_st.irq = next_st.conversion_done_request
			&& next_st.conversion_done_irq_enable; // see [RULE15]
	end

	always_ff @(posedge core_clk_in) begin
		st <= next_st;
	end

	assign rd_data_out = st.rd_data;
	assign channel_out = st.channel;
	assign channel_valid_out = st.channel_valid;
	assign sample_out = st.sample;
	assign trial_code_out = sar_code;
	assign conversion_active_out = st.conversion_active_flag;
	assign irq_out = st.irq;

	// helper: length of the current busy period
	logic [6:0] span;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			span <= 7'h00;
		end else if (st.conversion_active_flag) begin
			span <= span + 7'h01;
		end else begin
			span <= 7'h00;
		end
	end

	// helper: a result has been stored since reset; power-up result is undefined
	logic result_known;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			result_known <= 1'b0;
		end else if (st.done_seen) begin
			result_known <= 1'b1;
		end
	end

	a_conv_length: assert property ( // see [RULE7]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		st.done_seen |-> span == {1'b0, (st.run_speed ? sar_adc_pkg::FAST_CYCLES
			: sar_adc_pkg::SLOW_CYCLES)}
	) else $error("conversion length does not match speed select");

	a_start_sets_flag: assert property ( // see [RULE13]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(start_write && !st.conversion_active_flag && !standby) |=> conversion_active_out
			##1 conversion_active_out
	) else $error("software start did not set the busy flag");

	a_stop_clears: assert property ( // see [RULE13]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		stop_write |=> !conversion_active_out && !$rose(st.conversion_done_request)
	) else $error("stop write did not end conversion quietly");

	a_result_hold: assert property ( // see [RULE2]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(result_known && !st.conversion_active_flag && !sar_start) |=> $stable(st.result)
	) else $error("result changed while idle");

	a_result_split: assert property ( // see [RULE3]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(rd_in && addr_in == sar_adc_pkg::ADDR_RESULT_LOW) |=>
			rd_data_out == {$past(st.result[1:0]), 6'h00}
	) else $error("low result byte misplaced");

	a_trig_ignored: assert property ( // see [RULE9]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(!st.ext_trigger_enable && !st.conversion_active_flag && !wr_start)
			|=> !conversion_active_out
	) else $error("trigger started a conversion while disabled");

	a_trig_starts: assert property ( // see [RULE10]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(st.ext_trigger_enable && trig_pulse && !st.conversion_active_flag && !standby
			&& !wr_start) |=> conversion_active_out && sar_code == sar_adc_pkg::SAR_FIRST_TRIAL
	) else $error("qualifying trigger edge did not start conversion");

	a_irq_on_done: assert property ( // see [RULE11]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		(done_ok && st.conversion_done_irq_enable && !wr_in) |=> irq_out && !conversion_active_out
	) else $error("completion did not raise the interrupt");

	a_irq_gated: assert property ( // see [RULE15]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		irq_out |-> st.conversion_done_irq_enable && st.conversion_done_request
	) else $error("interrupt without enabled request");

	a_standby_idle: assert property ( // see [RULE12]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		standby |=> !conversion_active_out
	) else $error("converter busy in module standby");

	a_chan_decode: assert property ( // see [RULE14]
		@(posedge core_clk_in) disable iff (sys_rst_in)
		channel_valid_out |-> $past(next_st.channel_select[3]) != $past(next_st.channel_select[2])
	) else $error("channel marked valid for a barred code");
endmodule // sar_adc_control

// ### verification/analog_front_model.sv
// comparator and sample-and-hold stand-in for the eight analog inputs
`timescale 1ns/1ns
module analog_front_model #(
	parameter logic [79:0] LEVELS = 80'h0
) (
	input wire logic core_clk_in,
	input wire logic [2:0] channel_in,
	input wire logic channel_valid_in,
	input wire logic sample_in,
	input wire logic [9:0] trial_code_in,
	output logic comparator_out
);
	logic [9:0] held = 10'h000;
	logic noise = 1'b0;
	// held tracks the chosen input only while sampling, like a real hold cap
	always @(posedge core_clk_in) begin
		noise <= ~noise;
		if (sample_in) held <= LEVELS[channel_in * 10 +: 10];
	end
	// no channel means a floating input: the answer flips every cycle
	assign comparator_out = channel_valid_in ? (held >= trial_code_in) : noise;
endmodule // analog_front_model

// ### verification/sar_adc_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module sar_adc_control_bench;
	localparam logic [79:0] LEVELS = {10'h03f, 10'h3c0, 10'h1fe, 10'h201, 10'h155, 10'h2aa,
		10'h000, 10'h3ff};
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic ext_trigger_pin_in = 1'b0;
	logic trigger_edge_select_in = 1'b1;
	logic comparator_in;
	logic [7:0] rd_data_out;
	logic [2:0] channel_out;
	logic channel_valid_out, sample_out, conversion_active_out, irq_out;
	logic [9:0] trial_code_out;
	logic [7:0] rd_val, busy_len;
	logic [3:0] ch;
	int err_count = 0;
	int checked = 0;

	initial forever #50 core_clk_in = ~core_clk_in;

	sar_adc_control dut_u (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.ext_trigger_pin_in(ext_trigger_pin_in), .trigger_edge_select_in(trigger_edge_select_in),
		.comparator_in(comparator_in), .channel_out(channel_out),
		.channel_valid_out(channel_valid_out), .sample_out(sample_out),
		.trial_code_out(trial_code_out), .conversion_active_out(conversion_active_out),
		.irq_out(irq_out));

	analog_front_model #(.LEVELS(LEVELS)) front_u (.core_clk_in(core_clk_in),
		.channel_in(channel_out), .channel_valid_in(channel_valid_out), .sample_in(sample_out),
		.trial_code_in(trial_code_out), .comparator_out(comparator_in));

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check1(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic reg_rd(input logic [15:0] a);
		@(posedge core_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		@(negedge core_clk_in);
		rd_val = rd_data_out;
	endtask

	// counts busy cycles from the start write until the flag drops
	task automatic convert(output logic [7:0] len);
		reg_wr(sar_adc_pkg::ADDR_START, 8'h80);
		len = 8'h00;
		for (int i = 0; i < 200; i++) begin
			@(negedge core_clk_in);
			if (i == 0) begin
				check1("sample start", 1'b1, sample_out);
				check8("first trial", 8'h80, trial_code_out[9:2]);
			end
			if (conversion_active_out !== 1'b1) break;
			len++;
		end
		check1("sample end", 1'b0, sample_out);
	endtask

	task automatic wait_busy(input logic want);
		for (int i = 0; i < 100 && conversion_active_out !== want; i++) @(negedge core_clk_in);
	endtask

	task automatic check_result(input logic [9:0] lvl);
		reg_rd(sar_adc_pkg::ADDR_RESULT_HIGH);
		check8("result high", lvl[9:2], rd_val);
		reg_rd(sar_adc_pkg::ADDR_RESULT_LOW);
		check8("result low", {lvl[1:0], 6'h00}, rd_val);
	endtask

	task automatic give_verdict();
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		reg_rd(sar_adc_pkg::ADDR_MODE);
		check8("mode reset", 8'h30, rd_val);
		reg_rd(sar_adc_pkg::ADDR_START);
		check8("start reset", 8'h7f, rd_val);
		reg_rd(sar_adc_pkg::ADDR_CLOCK_GATE);
		check8("gate reset", 8'hff, rd_val);
		reg_rd(16'hffd0);
		check8("unmapped", 8'h00, rd_val);
		reg_wr(sar_adc_pkg::ADDR_IRQ_ENABLE, 8'h01);
		// fast setting only on the last input: below the guaranteed time, kept for the count
		for (int k = 0; k < 8; k++) begin
			ch = (k < 4) ? {2'b01, k[1:0]} : {2'b10, k[1:0]};
			reg_wr(sar_adc_pkg::ADDR_MODE, {k == 7, 3'b000, ch});
			reg_rd(sar_adc_pkg::ADDR_MODE);
			check8("mode", {k == 7, 1'b0, 2'b11, ch}, rd_val);
			check8("channel", {5'h00, k[2:0]}, {5'h00, channel_out});
			check1("channel valid", 1'b1, channel_valid_out);
			reg_rd(sar_adc_pkg::ADDR_SPEED_INFO);
			check8("speed info", {7'h00, k == 7}, rd_val);
			convert(busy_len);
			check8("busy length", (k == 7) ? 8'h1f : 8'h3e, busy_len);
			check1("irq", 1'b1, irq_out);
			check_result(LEVELS[k * 10 +: 10]);
			reg_rd(sar_adc_pkg::ADDR_IRQ_STATUS);
			check8("status", 8'h01, rd_val);
			reg_wr(sar_adc_pkg::ADDR_IRQ_CLEAR, 8'h01);
			@(negedge core_clk_in);
			check1("irq cleared", 1'b0, irq_out);
		end
		reg_wr(sar_adc_pkg::ADDR_IRQ_ENABLE, 8'h00);
		convert(busy_len);
		check8("busy length fast", 8'h1f, busy_len);
		check1("irq masked", 1'b0, irq_out);
		reg_rd(sar_adc_pkg::ADDR_IRQ_STATUS);
		check8("status masked", 8'h01, rd_val);
		reg_wr(sar_adc_pkg::ADDR_IRQ_CLEAR, 8'h01);
		reg_wr(sar_adc_pkg::ADDR_RESULT_HIGH, 8'h00);
		check_result(LEVELS[79:70]);
		// stop in mid-run: no new result and no done request
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h04);
		reg_wr(sar_adc_pkg::ADDR_START, 8'h80);
		reg_rd(sar_adc_pkg::ADDR_START);
		check8("start busy", 8'hff, rd_val);
		reg_wr(sar_adc_pkg::ADDR_START, 8'h00);
		@(negedge core_clk_in);
		check1("stopped", 1'b0, conversion_active_out);
		repeat (70) @(negedge core_clk_in);
		reg_rd(sar_adc_pkg::ADDR_IRQ_STATUS);
		check8("status stopped", 8'h00, rd_val);
		check_result(LEVELS[79:70]);
		// trigger pin ignored while disabled, then starts on a rising and on a falling edge
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h05);
		ext_trigger_pin_in <= 1'b1;
		repeat (10) @(negedge core_clk_in);
		check1("trigger off", 1'b0, conversion_active_out);
		@(posedge core_clk_in);
		ext_trigger_pin_in <= 1'b0;
		repeat (5) @(posedge core_clk_in);
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h45);
		ext_trigger_pin_in <= 1'b1;
		wait_busy(1'b1);
		check1("rising trigger", 1'b1, conversion_active_out);
		wait_busy(1'b0);
		check_result(LEVELS[19:10]);
		@(posedge core_clk_in);
		trigger_edge_select_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		ext_trigger_pin_in <= 1'b0;
		wait_busy(1'b1);
		check1("falling trigger", 1'b1, conversion_active_out);
		wait_busy(1'b0);
		check_result(LEVELS[19:10]);
		// standby refuses a start; barred and empty channel codes select nothing
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h04);
		reg_wr(sar_adc_pkg::ADDR_CLOCK_GATE, 8'hef);
		reg_rd(sar_adc_pkg::ADDR_CLOCK_GATE);
		check8("gate", 8'hef, rd_val);
		reg_wr(sar_adc_pkg::ADDR_START, 8'h80);
		@(negedge core_clk_in);
		check1("standby", 1'b0, conversion_active_out);
		reg_wr(sar_adc_pkg::ADDR_CLOCK_GATE, 8'hff);
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h0c);
		@(negedge core_clk_in);
		check1("barred channel", 1'b0, channel_valid_out);
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h02);
		@(negedge core_clk_in);
		check1("no channel", 1'b0, channel_valid_out);
		// reset in mid-run keeps a non-zero result
		reg_wr(sar_adc_pkg::ADDR_MODE, 8'h06);
		convert(busy_len);
		check_result(LEVELS[29:20]);
		reg_wr(sar_adc_pkg::ADDR_START, 8'h80);
		repeat (20) @(posedge core_clk_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		@(negedge core_clk_in);
		check1("busy after reset", 1'b0, conversion_active_out);
		reg_rd(sar_adc_pkg::ADDR_MODE);
		check8("mode after reset", 8'h30, rd_val);
		check_result(LEVELS[29:20]);
		give_verdict();
	end
endmodule // sar_adc_control_bench
